// File: rtl/cse_alu.sv
`timescale 1ns/1ps
`default_nettype none
module cse_alu (
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] flags,
  output logic      [7:0] acc_out,
  output logic      [7:0] flags_out,
  output logic      [7:0] mem_out,
  output logic            acc_wr,
  output logic            mem_wr,
  output logic            taken,
  output logic            illegal
);
  logic [8:0] bin_sum;
  logic [4:0] lo;
  logic [4:0] hi;
  logic [7:0] res;
  logic [7:0] shin;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bin_sum = {1'b0, acc} + {1'b0, operand} + {8'h00, flags[cse_pkg::FL_C]};
    lo = {1'b0, acc[3:0]} + {1'b0, operand[3:0]}
         + {4'h0, flags[cse_pkg::FL_C]};
    if (lo > cse_pkg::BCD_MAX) begin
      lo = lo + cse_pkg::BCD_ADJ;
    end
    hi = {1'b0, acc[7:4]} + {1'b0, operand[7:4]} + {4'h0, lo[4]};
    if (hi > cse_pkg::BCD_MAX) begin
      hi = hi + cse_pkg::BCD_ADJ;
    end
    shin      = (opcode == cse_pkg::OP_ASL_ACC) ? acc : operand;
    res       = 8'h00;
    acc_out   = acc;
    mem_out   = operand;
    flags_out = flags;
    acc_wr    = 1'b0;
    mem_wr    = 1'b0;
    taken     = 1'b0;
    illegal   = 1'b0;
    case (opcode)
      8'h6d, 8'h7d, 8'h79, 8'h69, 8'h65, 8'h61, 8'h75, 8'h72, 8'h71: begin
        res = bin_sum[7:0];
        flags_out[cse_pkg::FL_C] = bin_sum[8];
        if (flags[cse_pkg::FL_D]) begin
          res = {hi[3:0], lo[3:0]};
          flags_out[cse_pkg::FL_C] = hi[4];
        end
        // Overflow follows the binary sum in both modes
        flags_out[cse_pkg::FL_V] = (acc[7] == operand[7])
                                   && (bin_sum[7] != acc[7]);
        acc_out = res;
        acc_wr  = 1'b1;
      end
      8'h2d, 8'h3d, 8'h39, 8'h29, 8'h25, 8'h21, 8'h35, 8'h32, 8'h31: begin
        res     = acc & operand;
        acc_out = res;
        acc_wr  = 1'b1;
      end
      8'h0e, 8'h1e, 8'h0a, 8'h06, 8'h16: begin
        // shift left, bit 7 to carry
        res = {shin[6:0], 1'b0};
        flags_out[cse_pkg::FL_C] = shin[7];
        if (opcode == cse_pkg::OP_ASL_ACC) begin
          acc_out = res;
          acc_wr  = 1'b1;
        end else begin
          mem_out = res;
          mem_wr  = 1'b1;
        end
      end
      default: begin
        // branch on bit clear, flags untouched
        if (opcode[3:0] == cse_pkg::OP_BBR_LO && !opcode[7]) begin
          taken = !operand[opcode[6:4]];
        end else begin
          illegal = 1'b1;
        end
      end
    endcase
    if (acc_wr || mem_wr) begin
      flags_out[cse_pkg::FL_N] = res[7];
      flags_out[cse_pkg::FL_Z] = (res == 8'h00);
    end
  end
endmodule // cse_alu
`default_nettype wire

// File: rtl/cse_pkg.sv
package cse_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_OPCODE  = 8'h04;
  localparam logic [7:0] OFS_OPERAND = 8'h08;
  localparam logic [7:0] OFS_BR_OFS  = 8'h0c;
  localparam logic [7:0] OFS_ACC     = 8'h10;
  localparam logic [7:0] OFS_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_PC      = 8'h18;
  localparam logic [7:0] OFS_RESULT  = 8'h1c;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  // Flag bit positions in processor_flags
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_I = 2;
  localparam int FL_D = 3;
  localparam int FL_V = 6;
  localparam int FL_N = 7;
  localparam logic [7:0] FLAGS_ONES  = 8'h30;
  localparam logic [7:0] FLAGS_RST   = 8'h34;
  // Control and status bits
  localparam int CTRL_EXEC = 0;
  localparam int ST_DONE   = 0;
  localparam int ST_TAKEN  = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_MEM_WR = 3;
  // Opcodes that are not a plain list
  localparam logic [7:0] OP_ASL_ACC = 8'h0a;
  localparam logic [3:0] OP_BBR_LO  = 4'hf;
  // Decimal correction
  localparam logic [4:0] BCD_MAX    = 5'h09;
  localparam logic [4:0] BCD_ADJ    = 5'h06;
  // Reset values and bus answers
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

// File: rtl/cse_top.sv
// Function
// - add-with-carry sums accumulator, operand, carry
// - AND operand into accumulator, N Z only
// - shift left, bit 7 to carry
// - branch on memory bit clear, flags kept
// - flags layout N V 1 1 D I Z C
// - fully static, clock may stop freely
`timescale 1ns/1ps
`default_nettype none
module cse_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  logic [7:0]        opcode_reg;
  logic [7:0]        operand_reg;
  logic [7:0]        br_ofs_reg;
  logic [7:0]        acc_reg;
  logic [7:0]        flags_reg;
  logic [15:0]       pc_reg;
  logic [7:0]        result_reg;
  logic [3:0]        status_reg;
  logic              exec_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [7:0]        waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wr_do;
  logic              wr_hit;
  logic [7:0]        raddr;
  logic [31:0]       rdata_next;
  logic              rhit_next;
  logic [7:0]        alu_acc;
  logic [7:0]        alu_flags;
  logic [7:0]        alu_mem;
  logic              alu_acc_wr;
  logic              alu_mem_wr;
  logic              alu_taken;
  logic              alu_illegal;

  cse_alu u_alu (
    .opcode    (opcode_reg),
    .acc       (acc_reg),
    .operand   (operand_reg),
    .flags     (flags_reg),
    .acc_out   (alu_acc),
    .flags_out (alu_flags),
    .mem_out   (alu_mem),
    .acc_wr    (alu_acc_wr),
    .mem_wr    (alu_mem_wr),
    .taken     (alu_taken),
    .illegal   (alu_illegal)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order
  assign wr_do  = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_hit = (waddr_reg == cse_pkg::OFS_CTRL)
               || (waddr_reg == cse_pkg::OFS_OPCODE)
               || (waddr_reg == cse_pkg::OFS_OPERAND)
               || (waddr_reg == cse_pkg::OFS_BR_OFS)
               || (waddr_reg == cse_pkg::OFS_ACC)
               || (waddr_reg == cse_pkg::OFS_FLAGS)
               || (waddr_reg == cse_pkg::OFS_PC);

  // every flop holds while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      waddr_reg     <= cse_pkg::BYTE_RST;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cse_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_reg     <= 8'(s_axi_awaddr);
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? cse_pkg::RESP_OKAY : cse_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        // Ready again only after the response, one write in flight
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-loaded instruction fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opcode_reg  <= cse_pkg::BYTE_RST;
      operand_reg <= cse_pkg::BYTE_RST;
      br_ofs_reg  <= cse_pkg::BYTE_RST;
      exec_reg    <= 1'b0;
    end else if (ce) begin
      exec_reg <= wr_do && (waddr_reg == cse_pkg::OFS_CTRL)
                  && wstrb_reg[0] && wdata_reg[cse_pkg::CTRL_EXEC];
      if (wr_do && wstrb_reg[0]) begin
        if (waddr_reg == cse_pkg::OFS_OPCODE) begin
          opcode_reg <= wdata_reg[7:0];
        end else if (waddr_reg == cse_pkg::OFS_OPERAND) begin
          operand_reg <= wdata_reg[7:0];
        end else if (waddr_reg == cse_pkg::OFS_BR_OFS) begin
          br_ofs_reg <= wdata_reg[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state: execution wins, bus writes are idle then anyway
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg   <= cse_pkg::BYTE_RST;
      flags_reg <= cse_pkg::FLAGS_RST;
      pc_reg    <= cse_pkg::PC_RST;
    end else if (ce) begin
      if (exec_reg) begin
        if (alu_acc_wr) begin
          acc_reg <= alu_acc;
        end
        flags_reg <= alu_flags;
        // relative branch when the bit is clear
        if (alu_taken) begin
          pc_reg <= pc_reg + {{8{br_ofs_reg[7]}}, br_ofs_reg};
        end
      end else if (wr_do) begin
        if (waddr_reg == cse_pkg::OFS_ACC && wstrb_reg[0]) begin
          acc_reg <= wdata_reg[7:0];
        end else if (waddr_reg == cse_pkg::OFS_FLAGS && wstrb_reg[0]) begin
          flags_reg <= wdata_reg[7:0];
        end else if (waddr_reg == cse_pkg::OFS_PC) begin
          if (wstrb_reg[0]) begin
            pc_reg[7:0] <= wdata_reg[7:0];
          end
          if (wstrb_reg[1]) begin
            pc_reg[15:8] <= wdata_reg[15:8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outcome of the last execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= cse_pkg::BYTE_RST;
      status_reg <= 4'h0;
    end else if (ce) begin
      if (exec_reg) begin
        result_reg <= alu_mem;
        status_reg[cse_pkg::ST_DONE]    <= 1'b1;
        status_reg[cse_pkg::ST_TAKEN]   <= alu_taken;
        status_reg[cse_pkg::ST_ILLEGAL] <= alu_illegal;
        status_reg[cse_pkg::ST_MEM_WR]  <= alu_mem_wr;
      end else if (wr_do && waddr_reg == cse_pkg::OFS_CTRL) begin
        status_reg[cse_pkg::ST_DONE] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  assign raddr = 8'(s_axi_araddr);

  always_comb begin
    rdata_next = 32'h0000_0000;
    rhit_next  = 1'b1;
    if (raddr == cse_pkg::OFS_CTRL) begin
      rdata_next = 32'h0000_0000;
    end else if (raddr == cse_pkg::OFS_OPCODE) begin
      rdata_next[7:0] = opcode_reg;
    end else if (raddr == cse_pkg::OFS_OPERAND) begin
      rdata_next[7:0] = operand_reg;
    end else if (raddr == cse_pkg::OFS_BR_OFS) begin
      rdata_next[7:0] = br_ofs_reg;
    end else if (raddr == cse_pkg::OFS_ACC) begin
      rdata_next[7:0] = acc_reg;
    end else if (raddr == cse_pkg::OFS_FLAGS) begin
      // bits 5 and 4 always read one
      rdata_next[7:0] = flags_reg | cse_pkg::FLAGS_ONES;
    end else if (raddr == cse_pkg::OFS_PC) begin
      rdata_next[15:0] = pc_reg;
    end else if (raddr == cse_pkg::OFS_RESULT) begin
      rdata_next[7:0] = result_reg;
    end else if (raddr == cse_pkg::OFS_STATUS) begin
      rdata_next[3:0] = status_reg;
    end else begin
      rhit_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cse_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_next;
        s_axi_rresp   <= rhit_next ? cse_pkg::RESP_OKAY
                                   : cse_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // cse_top
`default_nettype wire

// File: tb/cse_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory bytes that supply the operands; fixed scrambled pattern
module cse_mem_model (
  input  wire logic [7:0] addr,
  output logic      [7:0] data
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 11);
  assign data = mem[addr];
endmodule // cse_mem_model
`default_nettype wire

// File: tb/cse_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module cse_top_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Address of the read now answering
  logic [ADDR_W-1:0] ar_reg;
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready && ce) ar_reg <= s_axi_araddr;
  ////////////////////////////////////////////////////////////////////////////
  property p_freeze;
    !ce |=> $stable({s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp,
      s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp});
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved, ce low");
  property p_flag_ones;
    s_axi_rvalid && ar_reg[7:0] == cse_pkg::OFS_FLAGS
      |-> s_axi_rdata[5:4] == 2'b11 && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_flag_ones: assert property (p_flag_ones) else $error("flag bits 5:4 bad");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rlat;
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  property p_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_block: assert property (p_block) else $error("write taken while busy");
  property p_unmapped;
    s_axi_rvalid && ar_reg[7:0] > cse_pkg::OFS_STATUS
      |-> s_axi_rresp == cse_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read ok");
endmodule // cse_top_props
bind cse_top cse_top_props #(.ADDR_W(ADDR_W)) u_props (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: tb/test_cpu_opcode_subset_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_opcode_subset_exec;
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, mem_addr, mem_data;
  logic [31:0] wdata, rdata, exp_q[$];
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp_q[$], bsp_q[$];
  int          n_fail = 0, checked = 0, cyc = 0, seed = 32'h5bb3a281;
  logic [7:0]  ops [31] = '{8'h6d, 8'h7d, 8'h79, 8'h69, 8'h65, 8'h61, 8'h75,
    8'h72, 8'h71, 8'h2d, 8'h3d, 8'h39, 8'h29, 8'h25, 8'h21, 8'h35, 8'h32,
    8'h31, 8'h0e, 8'h1e, 8'h0a, 8'h06, 8'h16, 8'h0f, 8'h1f, 8'h2f, 8'h3f,
    8'h4f, 8'h5f, 8'h6f, 8'h7f};
  cse_top #(.ADDR_W(8)) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cse_mem_model mem (.addr(mem_addr), .data(mem_data));
  ////////////////////////////////////////////////////////////////////////////
  task cmp_d(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp_r(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ready may start low but is raised before the answer arrives, so the held-answer path is not exercised
  task wr(input logic [7:0] a, input logic [31:0] d,
          input logic [1:0] r = cse_pkg::RESP_OKAY);
    logic done;
    bsp_q.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($random(seed));
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid && bready;
      bready <= !done;
    end while (!done);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e,
          input logic [1:0] r = cse_pkg::RESP_OKAY);
    logic done;
    exp_q.push_back(e);
    rsp_q.push_back(r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($random(seed));
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      done = rvalid && rready;
      rready <= !done;
    end while (!done);
  endtask
  // k: 0 add, 1 and, 2 shift, 3 bit-clear branch; dec picks decimal mode
  task chk(input logic [7:0] op, input int k, input logic dec);
    logic [7:0]  a, m, f, o, ea, res, st, v, t, sh;
    logic [8:0]  s;
    logic [4:0]  lo, hi;
    logic [15:0] pc, pn;
    logic        vv, c;
    a = 8'($random(seed));
    o = 8'($random(seed));
    pc = 16'($random(seed));
    f = 8'($random(seed));
    f[cse_pkg::FL_D] = dec;
    mem_addr <= 8'($random(seed));
    @(posedge aclk);
    m = mem_data;
    if (dec) begin
      a = a & 8'h77;
      m = m & 8'h77;
    end
    wr(cse_pkg::OFS_ACC, {24'h0, a});
    wr(cse_pkg::OFS_OPERAND, {24'h0, m});
    wr(cse_pkg::OFS_FLAGS, {24'h0, f});
    wr(cse_pkg::OFS_PC, {16'h0, pc});
    wr(cse_pkg::OFS_BR_OFS, {24'h0, o});
    wr(cse_pkg::OFS_OPCODE, {24'h0, op});
    wr(cse_pkg::OFS_CTRL, 32'h1);
    ea = a;
    res = m;
    st = 8'h1;
    v = a;
    vv = f[6];
    c = f[0];
    pn = pc;
    case (k)
      0: begin
        s = a + m + f[0];
        t = ~(a ^ m) & (a ^ s[7:0]);
        vv = t[7];
        {c, v} = s;
        if (dec) begin
          lo = a[3:0] + m[3:0] + f[0];
          if (lo > 5'd9) lo = lo + 5'd6;
          hi = a[7:4] + m[7:4] + lo[4];
          if (hi > 5'd9) hi = hi + 5'd6;
          v = {hi[3:0], lo[3:0]};
          c = hi[4];
        end
        ea = v;
      end
      1: begin
        ea = a & m;
        v = ea;
      end
      2: begin
        sh = (op == 8'h0a) ? a : m;
        v = {sh[6:0], 1'b0};
        c = sh[7];
        if (op == 8'h0a) ea = v;
        else begin
          res = v;
          st = 8'h9;
        end
      end
      default: if (!m[op[6:4]]) begin
        pn = pc + {{8{o[7]}}, o};
        st = 8'h3;
      end
    endcase
    rd(cse_pkg::OFS_ACC, {24'h0, ea});
    if (k == 3) rd(cse_pkg::OFS_FLAGS, {24'h0, f | 8'h30});
    else rd(cse_pkg::OFS_FLAGS, {24'h0, v[7], vv, 2'b11, f[3:2], v == 0, c});
    rd(cse_pkg::OFS_RESULT, {24'h0, res});
    rd(cse_pkg::OFS_STATUS, {24'h0, st});
    rd(cse_pkg::OFS_PC, {16'h0, pn});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      cmp_d(rdata, exp_q.pop_front());
      cmp_r(rresp, rsp_q.pop_front());
    end
    if (bvalid && bready) cmp_r(bresp, bsp_q.pop_front());
  end
  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, mem_addr, wdata} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cse_pkg::OFS_FLAGS, 32'h34);
    rd(8'h40, 32'h0, cse_pkg::RESP_SLVERR);
    wr(8'h40, 32'hff, cse_pkg::RESP_SLVERR);
    wr(cse_pkg::OFS_FLAGS, 32'h0);
    rd(cse_pkg::OFS_FLAGS, 32'h30);
    foreach (ops[i]) chk(ops[i], i < 9 ? 0 : i < 18 ? 1 : i < 23 ? 2 : 3, 1'b0);
    for (int i = 0; i < 9; i++) chk(ops[i], 0, 1'b1);
    wr(cse_pkg::OFS_ACC, 32'ha5);
    ce <= 1'b0;
    repeat (6) @(posedge aclk);
    ce <= 1'b1;
    rd(cse_pkg::OFS_ACC, 32'ha5);
    // Mid-run reset, then lane strobes, illegal opcode and done clearing
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cse_pkg::OFS_ACC, 32'h0);
    rd(cse_pkg::OFS_FLAGS, 32'h34);
    wstrb <= 4'h2;
    wr(cse_pkg::OFS_PC, 32'h0000_abcd);
    wstrb <= 4'hf;
    rd(cse_pkg::OFS_PC, 32'h0000_ab00);
    wr(cse_pkg::OFS_OPCODE, 32'h8f);
    wr(cse_pkg::OFS_CTRL, 32'h1);
    rd(cse_pkg::OFS_STATUS, 32'h5);
    rd(cse_pkg::OFS_ACC, 32'h0);
    rd(cse_pkg::OFS_FLAGS, 32'h34);
    wr(cse_pkg::OFS_CTRL, 32'h0);
    rd(cse_pkg::OFS_STATUS, 32'h4);
    @(posedge aclk);
    tally_and_finish;
  end
endmodule // test_cpu_opcode_subset_exec
`default_nettype wire
